// ---- rtl/brm_pkg.sv ----
// Shared constants and types for the broadcast route and acknowledgement merge block.
// Assumes eight byte links and route bytes with three-bit link bounds.
package brm_pkg;

    // Link count and route byte layout
    localparam int         NUM_LINKS      = 8;
    localparam int         LINK_IDX_W     = 3;
    localparam int         BOUND_W        = 3;
    localparam int         LOWER_LSB      = 0;
    localparam int         PRIO_BIT       = 3;
    localparam int         UPPER_LSB      = 4;
    localparam int         PARITY_BIT     = 7;
    localparam logic [2:0] BOUND_TOP      = 3'h7;
    localparam logic [2:0] BOUND_BOTTOM   = 3'h0;

    // Downward link limit taken from the error pin after reset
    localparam logic [2:0] LIMIT_PIN_HIGH = 3'h3;
    localparam logic [2:0] LIMIT_PIN_LOW  = 3'h7;
    localparam logic [2:0] LIMIT_RESET    = 3'h7;
    // Cycles after reset release before the synchronised pin is trusted
    localparam logic [1:0] STRAP_WAIT     = 2'h3;

    // Error flags, two per link
    localparam int         ERR_PER_LINK   = 2;
    localparam int         ERR_PHASE      = 0;
    localparam int         ERR_DATA       = 1;
    localparam int         ERR_W          = NUM_LINKS * ERR_PER_LINK;

    // Link reset hold after a line protocol error
    localparam int         LINK_RESET_CYCLES = 256;
    localparam int         RST_CNT_W         = 9;
    localparam logic [8:0] LINK_RESET_LOAD   = 9'(LINK_RESET_CYCLES - 1);

    // Width of the error pin and link-side inputs passed through the synchroniser
    localparam int         SYNC_W = 4 * NUM_LINKS + 3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FORWARD,
        ST_HOLD,
        ST_TAIL
    } brm_state_t;

endpackage

// ---- rtl/brm_sync.sv ----
// Two-stage synchroniser for levels entering from outside the clk domain.
// Assumes the inputs are levels that stay put for at least two clk periods.
module brm_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                stage1[b] <= 1'b0;
                dout[b]   <= 1'b0;
            end else begin
                stage1[b] <= din[b];
                dout[b]   <= stage1[b];
            end
        end
    end

endmodule // brm_sync

// ---- rtl/brm_switch.sv ----
// Broadcast route rewriting, acknowledgement merging and link error flags
// for one switch input of an eight-link byte switch.
// Assumes route bytes come from same-clock logic and link events arrive as
// levels sampled on the rising edge of the free-running link clock.

//Contract
// R1: Sample error pin at reset exit for limit.
// R2: Error pin released while in reset.
// R3: Configuration write overrides the downward limit.
// R4: Route byte holds upper and lower bounds.
// R5: Rewrite later bytes per output edge position.
// R6: Upper bound seven becomes the downward limit.
// R7: Full-range broadcast bytes pass unchanged.
// R8: Flip parity only for changed bits.
// R9: Sender waits for an answer before end marker.
// R10: Receiver accepts only when ack requested.
// R11: Answer only after all outputs answered.
// R12: Any reject gives one merged reject.
// R13: Connection held until end marker arrives.
// R14: Sender follows the broadcast packet sequence.
// R15: End markers release the switch connection.
// R16: Sticky flag per link per error type.
// R17: All flags ORed onto error pin.
// R18: Flags clear only by clear or reset.
// R19: Phase loss sets the phase flag.
// R20: Invalid symbol sets the data flag.
// R21: Line error holds link reset 256 cycles.
// R22: Errors close packets and notify both ends.
// R23: Bit three priority, odd parity byte.
// R24: Outputs from lower to upper inclusive.
// R25: Fixed route byte field positions.
module brm_switch (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // Open-drain error pin
    input  wire logic                      errPinIn,
    output logic                           errPinOut,
    output logic                           errPinOe_n,
    // Configuration
    input  wire logic                      cfgLimitWrite,
    input  wire logic [2:0]                cfgLimit,
    output logic      [2:0]                downLinkLimit,
    // Error flags
    input  wire logic [brm_pkg::ERR_W-1:0] errFlagClear,
    output logic      [brm_pkg::ERR_W-1:0] errFlags,
    // Route bytes from the receiving input
    input  wire logic [2:0]                srcLink,
    input  wire logic                      routeValid,
    input  wire logic [7:0]                routeByte,
    input  wire logic                      nextRouteValid,
    input  wire logic [7:0]                nextRouteByte,
    // Route bytes to the outputs
    output logic      [7:0]                outSel,
    output logic                           outRouteValid,
    output logic      [7:0][7:0]           outRouteByte,
    // Link clock and link events
    input  wire logic                      linkClk,
    input  wire logic [7:0]                ackAcceptIn,
    input  wire logic [7:0]                ackRejectIn,
    input  wire logic                      eopIn,
    input  wire logic [7:0]                rxPhaseLost,
    input  wire logic [7:0]                rxSymInvalid,
    // Answers and link control
    output logic                           ackOutValid,
    output logic                           ackOutAccept,
    output logic                           eopOut,
    output logic                           badEopOut,
    output logic      [7:0]                linkReset
);

    typedef struct packed {
        brm_pkg::brm_state_t               state;
        logic [1:0]                        strapCnt;
        logic                              strapDone;
        logic [2:0]                        limit;
        logic [brm_pkg::ERR_W-1:0]         flags;
        logic                              errOe_n;
        logic                              linkClkQ;
        logic [2:0]                        src;
        logic [7:0]                        sel;
        logic [2:0]                        lowest;
        logic [2:0]                        highest;
        logic                              bcast;
        logic [7:0]                        pending;
        logic                              anyReject;
        logic                              ackSent;
        logic                              ackOutValid;
        logic                              ackOutAccept;
        logic                              outRouteValid;
        logic [7:0][7:0]                   outRouteByte;
        logic                              eopOut;
        logic                              badEopOut;
        logic [7:0][brm_pkg::RST_CNT_W-1:0] rstCnt;
        logic [7:0]                        linkReset;
    } brm_regs_t;

    brm_regs_t r;
    brm_regs_t next_r;

    logic [brm_pkg::SYNC_W-1:0] syncIn;
    logic [brm_pkg::SYNC_W-1:0] syncOut;

    // Pin levels and link-side events cross through two flip-flops
    assign syncIn = {errPinIn, linkClk, eopIn, ackAcceptIn, ackRejectIn,
                     rxPhaseLost, rxSymInvalid};

    brm_sync #(
        .WIDTH (brm_pkg::SYNC_W)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (syncIn),
        .dout   (syncOut)
    );

    always_comb begin
        logic       pinS;
        logic       lcS;
        logic       edgeS;
        logic       eopEv;
        logic [7:0] accEv;
        logic [7:0] rejEv;
        logic [7:0] phaseEv;
        logic [7:0] dataEv;
        logic [7:0] lineErr;
        logic [7:0] mask;
        logic [7:0] srcMask;
        logic [brm_pkg::ERR_W-1:0] setVec;
        logic [2:0] lo;
        logic [2:0] up;
        logic       pri;
        logic [7:0] nb;
        logic [7:0] pend;
        logic       rej;
        pinS    = syncOut[brm_pkg::SYNC_W-1];
        lcS     = syncOut[brm_pkg::SYNC_W-2];
        // Events count only on a synced link clock rise
        edgeS   = lcS & ~r.linkClkQ;
        eopEv   = edgeS & syncOut[brm_pkg::SYNC_W-3];
        accEv   = edgeS ? syncOut[31:24] : 8'h00;
        rejEv   = edgeS ? syncOut[23:16] : 8'h00;
        phaseEv = edgeS ? syncOut[15:8] : 8'h00;
        dataEv  = edgeS ? syncOut[7:0] : 8'h00;
        lineErr = phaseEv | dataEv;
        mask    = 8'h00;
        srcMask = 8'h00;
        setVec  = '0;
        // R25: fixed field positions
        lo      = routeByte[brm_pkg::LOWER_LSB +: brm_pkg::BOUND_W];
        up      = routeByte[brm_pkg::UPPER_LSB +: brm_pkg::BOUND_W];
        pri     = routeByte[brm_pkg::PRIO_BIT];
        nb      = 8'h00;
        pend    = r.pending;
        rej     = r.anyReject;

        next_r               = r;
        next_r.linkClkQ      = lcS;
        next_r.ackOutValid   = 1'b0;
        next_r.outRouteValid = 1'b0;
        next_r.eopOut        = 1'b0;
        next_r.badEopOut     = 1'b0;

        // Wait lets the synchronised pin settle first
        // R1: strap limit from pin
        if (!r.strapDone) begin
            if (r.strapCnt == brm_pkg::STRAP_WAIT) begin
                next_r.limit     = pinS ? brm_pkg::LIMIT_PIN_HIGH : brm_pkg::LIMIT_PIN_LOW;
                next_r.strapDone = 1'b1;
            end else begin
                next_r.strapCnt = r.strapCnt + 2'h1;
            end
        end

        // R3: configuration write wins
        if (cfgLimitWrite) begin
            next_r.limit = cfgLimit;
        end

        for (int i = 0; i < brm_pkg::NUM_LINKS; i++) begin
            // R19: phase loss flag
            setVec[i * brm_pkg::ERR_PER_LINK + brm_pkg::ERR_PHASE] = phaseEv[i];
            // R20: invalid symbol flag
            setVec[i * brm_pkg::ERR_PER_LINK + brm_pkg::ERR_DATA]  = dataEv[i];
            // A retrigger reloads the full hold
            // R21: hold link reset
            if (lineErr[i]) begin
                next_r.rstCnt[i]    = brm_pkg::LINK_RESET_LOAD;
                next_r.linkReset[i] = 1'b1;
            end else if (r.rstCnt[i] != '0) begin
                next_r.rstCnt[i] = r.rstCnt[i] - 9'h001;
            end else begin
                next_r.linkReset[i] = 1'b0;
            end
        end

        // R16: per-link sticky bits
        // R18: set beats clear
        next_r.flags = (r.flags & ~errFlagClear) | setVec;

        // R6: upper seven becomes limit
        if (pri && up == brm_pkg::BOUND_TOP && r.limit != brm_pkg::BOUND_TOP) begin
            up = r.limit;
        end

        // R4: decode bounds
        // R24: inclusive output range
        for (int i = 0; i < brm_pkg::NUM_LINKS; i++) begin
            mask[i]    = (3'(i) >= lo) && (3'(i) <= up);
            srcMask[i] = (3'(i) == r.src);
        end

        case (r.state)
            brm_pkg::ST_IDLE, brm_pkg::ST_TAIL: begin
                // R15: second marker releases outputs
                if (r.state == brm_pkg::ST_TAIL && eopEv) begin
                    next_r.eopOut = 1'b1;
                    next_r.sel    = 8'h00;
                    next_r.state  = brm_pkg::ST_IDLE;
                end else if (routeValid) begin
                    next_r.src       = srcLink;
                    next_r.sel       = mask;
                    next_r.pending   = mask;
                    next_r.lowest    = lo;
                    next_r.highest   = up;
                    next_r.bcast     = pri;
                    next_r.anyReject = 1'b0;
                    next_r.ackSent   = 1'b0;
                    next_r.state     = brm_pkg::ST_FORWARD;
                    // Nobody to ask, so the sender gets a reject at once
                    if (mask == 8'h00) begin
                        next_r.ackOutValid  = 1'b1;
                        next_r.ackOutAccept = 1'b0;
                        next_r.ackSent      = 1'b1;
                        next_r.state        = brm_pkg::ST_HOLD;
                    end
                end
            end

            brm_pkg::ST_FORWARD: begin
                if (nextRouteValid) begin
                    next_r.outRouteValid = 1'b1;
                    for (int i = 0; i < brm_pkg::NUM_LINKS; i++) begin
                        nb = nextRouteByte;
                        // Range edges keep their outer bound
                        // R5: edge-dependent rewrite
                        // R23: only broadcast bytes
                        if (r.bcast && nextRouteByte[brm_pkg::PRIO_BIT]) begin
                            if (3'(i) >= r.lowest && 3'(i) < r.highest) begin
                                nb[brm_pkg::UPPER_LSB +: brm_pkg::BOUND_W] = brm_pkg::BOUND_TOP;
                            end
                            if (3'(i) > r.lowest && 3'(i) <= r.highest) begin
                                nb[brm_pkg::LOWER_LSB +: brm_pkg::BOUND_W] =
                                    brm_pkg::BOUND_BOTTOM;
                            end
                        end

                        // R7: full range stays equal
                        // R8: toggle parity by change
                        nb[brm_pkg::PARITY_BIT] = nextRouteByte[brm_pkg::PARITY_BIT]
                            ^ (^(nb[6:0] ^ nextRouteByte[6:0]));
                        next_r.outRouteByte[i] = nb;
                    end
                end

                // R12: remember any reject
                rej  = r.anyReject | (|(rejEv & r.pending));
                pend = r.pending & ~(accEv | rejEv);
                next_r.anyReject = rej;
                next_r.pending   = pend;

                // R11: answer once all answered
                if (pend == 8'h00) begin
                    next_r.ackOutValid  = 1'b1;
                    next_r.ackOutAccept = ~rej;
                    next_r.ackSent      = 1'b1;
                    next_r.state        = brm_pkg::ST_HOLD;
                end
            end

            brm_pkg::ST_HOLD: begin
                // R13: wait for first marker
                if (eopEv) begin
                    next_r.eopOut = 1'b1;
                    next_r.state  = brm_pkg::ST_TAIL;
                end
            end

            default: begin
                next_r.state = brm_pkg::ST_IDLE;
            end
        endcase

        // Error teardown overrides the state decision above
        // R22: terminate affected packet
        if (r.state != brm_pkg::ST_IDLE && (|(lineErr & (r.sel | srcMask)))) begin
            next_r.badEopOut = 1'b1;
            // R22: reject if still unanswered
            if (!r.ackSent) begin
                next_r.ackOutValid  = 1'b1;
                next_r.ackOutAccept = 1'b0;
            end
            next_r.eopOut        = 1'b0;
            next_r.outRouteValid = 1'b0;
            next_r.ackSent       = 1'b1;
            next_r.sel           = 8'h00;
            next_r.pending       = 8'h00;
            next_r.state         = brm_pkg::ST_IDLE;
        end

        // Releasing the pin lets the pull resistor set the strap
        // R2: released until strap taken
        // R17: OR of all flags
        next_r.errOe_n = ~(next_r.strapDone & (|next_r.flags));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r              <= '0;
            r.state        <= brm_pkg::ST_IDLE;
            // Limit reads seven until the pin is strapped
            r.limit        <= brm_pkg::LIMIT_RESET;
            r.errOe_n      <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Open drain: only ever pulls low
    assign errPinOut     = 1'b0;
    assign errPinOe_n    = r.errOe_n;
    assign downLinkLimit = r.limit;
    assign errFlags      = r.flags;
    assign outSel        = r.sel;
    assign outRouteValid = r.outRouteValid;
    assign outRouteByte  = r.outRouteByte;
    assign ackOutValid   = r.ackOutValid;
    assign ackOutAccept  = r.ackOutAccept;
    assign eopOut        = r.eopOut;
    assign badEopOut     = r.badEopOut;
    assign linkReset     = r.linkReset;

endmodule // brm_switch

// ---- verification/brm_switch_sva.sv ----
// Checker for the strap, flag, link reset and routing ports of brm_switch.
// Assumes a bind to brm_switch and a bench that never retriggers a link reset.
module brm_switch_sva (
    // Clock and reset
    input wire logic            clk,
    input wire logic            arst_n,
    // Pin and configuration
    input wire logic            errPinIn,
    input wire logic            errPinOe_n,
    input wire logic            cfgLimitWrite,
    input wire logic [2:0]      cfgLimit,
    input wire logic [2:0]      downLinkLimit,
    // Flags and link reset
    input wire logic [15:0]     errFlagClear,
    input wire logic [15:0]     errFlags,
    input wire logic [7:0]      linkReset,
    // Routing
    input wire logic            routeValid,
    input wire logic [7:0]      routeByte,
    input wire logic [7:0]      nextRouteByte,
    input wire logic [7:0]      outSel,
    input wire logic            outRouteValid,
    input wire logic [7:0][7:0] outRouteByte
);
    logic [9:0] runCnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    function automatic logic [7:0] rmask(input logic [2:0] lo, input logic [2:0] hi);
        rmask = 8'h0;
        for (int i = 0; i < 8; i++) begin
            rmask[i] = (i >= lo) && (i <= hi);
        end
    endfunction
    // Only link 2 is timed, the link the bench breaks with a phase loss
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            runCnt <= 10'h0;
        end else begin
            runCnt <= linkReset[2] ? runCnt + 10'h1 : 10'h0;
        end
    end
    pin_release_a: assert property (!$past(arst_n) |-> errPinOe_n)
        else $error("error pin driven just after reset");
    strap_high_a: assert property ($rose(arst_n) && errPinIn |-> ##5 downLinkLimit == 3'h3)
        else $error("limit not 3 after reset with pin high");
    strap_low_a: assert property ($rose(arst_n) && !errPinIn |-> ##5 downLinkLimit == 3'h7)
        else $error("limit not 7 after reset with pin low");
    cfg_write_a: assert property (cfgLimitWrite |=> downLinkLimit == $past(cfgLimit))
        else $error("limit write lost");
    sticky_flag_a: assert property ((($past(errFlags) & ~$past(errFlagClear)) & ~errFlags) == 16'h0)
        else $error("flag dropped without clear");
    pin_or_a: assert property ((!errPinOe_n) == (|errFlags))
        else $error("error pin does not follow flags");
    route_sel_a: assert property (
        routeValid && outSel == 8'h0 && !(routeByte[3] && routeByte[6:4] == 3'h7)
        |=> outSel == rmask($past(routeByte[2:0]), $past(routeByte[6:4])))
        else $error("outputs do not match bounds");
    limit_sub_a: assert property (
        routeValid && outSel == 8'h0 && routeByte[3] && routeByte[6:4] == 3'h7
        |=> outSel == rmask($past(routeByte[2:0]), $past(downLinkLimit)))
        else $error("upper bound not limited");
    parity_keep_a: assert property (
        outRouteValid && outSel[1] |-> ^outRouteByte[1] == ^$past(nextRouteByte))
        else $error("rewrite changed byte parity");
    reset_len_a: assert property ($fell(linkReset[2]) |-> runCnt == 10'h100)
        else $error("link reset length wrong");
endmodule // brm_switch_sva

// ---- verification/brm_link_model.sv ----
// Far side of the eight links: free-running link clock and event levels.
// Assumes the bench bumps reqId once per event set; a set stands one link period.
module brm_link_model (
    // Requests from the bench
    input  wire logic [7:0] reqId,
    input  wire logic       ackRequested,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] rej,
    input  wire logic       eop,
    input  wire logic [7:0] phase,
    input  wire logic [7:0] sym,
    // Link side
    output logic            linkClk,
    output logic [7:0]      ackAcceptIn,
    output logic [7:0]      ackRejectIn,
    output logic            eopIn,
    output logic [7:0]      rxPhaseLost,
    output logic [7:0]      rxSymInvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] doneId;
    initial begin
        linkClk = 1'b1;
        #3;
        forever #16 linkClk = ~linkClk;
    end
    // accept only when asked
    // Levels change at the falling link edge so one rise sees them settled
    always @(negedge linkClk) begin
        if (reqId !== doneId) begin
            ackAcceptIn <= ackRequested ? acc : 8'h0;
            ackRejectIn <= ackRequested ? rej : (rej | acc);
            {eopIn, rxPhaseLost, rxSymInvalid} <= {eop, phase, sym};
            doneId <= reqId;
        end else begin
            {ackAcceptIn, ackRejectIn, eopIn, rxPhaseLost, rxSymInvalid} <= 33'h0;
        end
    end
endmodule // brm_link_model

// ---- verification/tb_brm_switch.sv ----
// Self-checking bench for brm_switch with the link model on its far side.
// Assumes a 250 MHz clk; every input except the link side and the error pin changes at the falling clk edge.
module tb_brm_switch;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk, arst_n, pullLevel, errPinIn, errPinOut, errPinOe_n, eop;
    logic            cfgLimitWrite, routeValid, nextRouteValid, outRouteValid, eopIn;
    logic            ackOutValid, ackOutAccept, eopOut, badEopOut, ackRequested, linkClk;
    logic [2:0]      cfgLimit, downLinkLimit;
    logic [15:0]     errFlagClear, errFlags;
    logic [7:0]      routeByte, nextRouteByte, outSel, linkReset, reqId, acc, rej, phase, sym;
    logic [7:0]      ackAcceptIn, ackRejectIn, rxPhaseLost, rxSymInvalid;
    logic [7:0][7:0] outRouteByte, lastBytes;
    logic            lastAcc;
    int              errors, total_checks, ackCnt, eopCnt, badCnt;
    // Open-drain pin with a strap resistor to pullLevel
    assign errPinIn = errPinOe_n ? pullLevel : errPinOut;
    brm_switch brm_switch_i (.clk(clk), .arst_n(arst_n), .errPinIn(errPinIn),
        .errPinOut(errPinOut), .errPinOe_n(errPinOe_n), .cfgLimitWrite(cfgLimitWrite),
        .cfgLimit(cfgLimit), .downLinkLimit(downLinkLimit), .errFlagClear(errFlagClear),
        .errFlags(errFlags), .srcLink(3'h6), .routeValid(routeValid), .routeByte(routeByte),
        .nextRouteValid(nextRouteValid), .nextRouteByte(nextRouteByte), .outSel(outSel),
        .outRouteValid(outRouteValid), .outRouteByte(outRouteByte), .linkClk(linkClk),
        .ackAcceptIn(ackAcceptIn), .ackRejectIn(ackRejectIn), .eopIn(eopIn),
        .rxPhaseLost(rxPhaseLost), .rxSymInvalid(rxSymInvalid), .ackOutValid(ackOutValid),
        .ackOutAccept(ackOutAccept), .eopOut(eopOut), .badEopOut(badEopOut),
        .linkReset(linkReset));
    brm_link_model brm_link_model_i (.reqId(reqId), .ackRequested(ackRequested), .acc(acc),
        .rej(rej), .eop(eop), .phase(phase), .sym(sym), .linkClk(linkClk),
        .ackAcceptIn(ackAcceptIn), .ackRejectIn(ackRejectIn), .eopIn(eopIn),
        .rxPhaseLost(rxPhaseLost), .rxSymInvalid(rxSymInvalid));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // One-cycle pulses are caught at the edge that shows them
    always @(posedge clk) begin
        if (ackOutValid === 1'b1) begin
            ackCnt++;
            lastAcc = ackOutAccept;
        end
        if (eopOut === 1'b1) eopCnt++;
        if (badEopOut === 1'b1) badCnt++;
        if (outRouteValid === 1'b1) lastBytes = outRouteByte;
    end
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d total_checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rt(input logic [7:0] b, input logic nxt);
        {routeValid, nextRouteValid} = {!nxt, nxt};
        {routeByte, nextRouteByte} = {b, b};
        cyc(1);
        {routeValid, nextRouteValid} = 2'h0;
        cyc(2);
    endtask
    // Link latency is under 24 clk: two link edges plus the synchroniser
    task automatic link(input logic [7:0] a, input logic [7:0] r, input logic e,
                        input logic [7:0] p, input logic [7:0] s);
        {acc, rej, eop, phase, sym} = {a, r, e, p, s};
        reqId = reqId + 8'h1;
        cyc(24);
    endtask
    task automatic t_reset(input logic pull);
        {arst_n, pullLevel} = {1'b0, pull};
        cyc(3);
        chk("pin in reset", 16'(errPinOe_n), 16'h1);
        arst_n = 1'b1;
        cyc(6);
        chk("strap limit", 16'(downLinkLimit), pull ? 16'h3 : 16'h7);
        chk("flags after reset", errFlags, 16'h0);
    endtask
    task automatic t_cfg();
        {cfgLimit, cfgLimitWrite} = {3'h5, 1'b1};
        cyc(1);
        {cfgLimit, cfgLimitWrite} = {3'h3, 1'b1};
        chk("limit write", 16'(downLinkLimit), 16'h5);
        cyc(1);
        cfgLimitWrite = 1'b0;
        cyc(1);
    endtask
    // route bytes, answers, then two end markers
    task automatic t_bcast();
        int a0 = ackCnt;
        int e0 = eopCnt;
        rt(8'h49, 1'b0);
        chk("broadcast outSel", 16'(outSel), 16'h1e);
        rt(8'h29, 1'b1);
        chk("low edge byte", 16'(lastBytes[1]), 16'h79);
        chk("middle byte", 16'(lastBytes[2]), 16'hf8);
        chk("high edge byte", 16'(lastBytes[4]), 16'ha8);
        rt(8'hf8, 1'b1);
        chk("full range byte", 16'(lastBytes[1]), 16'hf8);
        link(8'h0e, 8'h0, 1'b0, 8'h0, 8'h0);
        chk("early answer", 16'(ackCnt - a0), 16'h0);
        ackRequested = 1'b0;
        link(8'h10, 8'h0, 1'b0, 8'h0, 8'h0);
        ackRequested = 1'b1;
        chk("merged count", 16'(ackCnt - a0), 16'h1);
        chk("merged reject", 16'(lastAcc), 16'h0);
        // end marker only after the answer
        link(8'h0, 8'h0, 1'b1, 8'h0, 8'h0);
        chk("held open", 16'(outSel), 16'h1e);
        link(8'h0, 8'h0, 1'b1, 8'h0, 8'h0);
        chk("released", 16'(outSel), 16'h0);
        chk("markers passed", 16'(eopCnt - e0), 16'h2);
    endtask
    task automatic t_limit_err();
        int b0 = badCnt;
        rt(8'h7a, 1'b0);
        chk("limited outSel", 16'(outSel), 16'h0c);
        link(8'h0c, 8'h0, 1'b0, 8'h0, 8'h0);
        chk("merged accept", 16'(lastAcc), 16'h1);
        link(8'h0, 8'h0, 1'b1, 8'h0, 8'h0);
        link(8'h0, 8'h0, 1'b1, 8'h0, 8'h0);
        rt(8'h7a, 1'b0);
        link(8'h0, 8'h0, 1'b0, 8'h04, 8'h0);
        chk("phase flag", errFlags, 16'h0010);
        chk("pin pulled", 16'(errPinOe_n), 16'h0);
        chk("link reset", 16'(linkReset), 16'h04);
        chk("terminated", 16'(badCnt - b0), 16'h1);
        chk("error reject", 16'(lastAcc), 16'h0);
        chk("dropped", 16'(outSel), 16'h0);
        cyc(250);
        chk("link reset over", 16'(linkReset), 16'h0);
    endtask
    task automatic t_flags();
        link(8'h0, 8'h0, 1'b0, 8'h0, 8'h20);
        chk("data flag", errFlags, 16'h0810);
        errFlagClear = 16'h0010;
        cyc(1);
        errFlagClear = 16'h0;
        cyc(2);
        chk("one flag cleared", errFlags, 16'h0800);
        t_reset(1'b0);
    endtask
    initial begin
        {arst_n, cfgLimitWrite, routeValid, nextRouteValid, eop, pullLevel} = 6'h1;
        {cfgLimit, routeByte, nextRouteByte, reqId} = 27'h0;
        {acc, rej, phase, sym, errFlagClear, ackRequested} = 49'h1;
        t_reset(1'b1);
        t_cfg();
        t_bcast();
        t_limit_err();
        t_flags();
        end_sim();
    end
    initial begin
        #20000;
        errors++;
        end_sim();
    end
endmodule // tb_brm_switch
bind brm_switch brm_switch_sva brm_switch_sva_i (.clk(clk), .arst_n(arst_n),
    .errPinIn(errPinIn), .errPinOe_n(errPinOe_n), .cfgLimitWrite(cfgLimitWrite),
    .cfgLimit(cfgLimit), .downLinkLimit(downLinkLimit), .errFlagClear(errFlagClear),
    .errFlags(errFlags), .linkReset(linkReset), .routeValid(routeValid),
    .routeByte(routeByte), .nextRouteByte(nextRouteByte), .outSel(outSel),
    .outRouteValid(outRouteValid), .outRouteByte(outRouteByte));
